// >>> verif/ee_mst.sv
`timescale 1ns/10ps
// Bus master model; SCL idles high between frames and each bit spans four quarters
module ee_mst (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (2 * n) @(posedge ref_clk);
  endtask
  // SDA moves only mid low phase, so it is steady around the rise
  task automatic bit_x(input logic b, output logic s);
    q(1);
    sda_pull <= !b;
    q(1);
    scl <= 1'b1;
    q(1);
    @(negedge ref_clk) s = sda;
    q(1);
    scl <= 1'b0;
  endtask
  task automatic start();
    q(1);
    sda_pull <= 1'b0;
    q(1);
    scl <= 1'b1;
    q(2);
    sda_pull <= 1'b1;
    q(2);
    scl <= 1'b0;
  endtask
  task automatic stop();
    q(1);
    sda_pull <= 1'b1;
    q(1);
    scl <= 1'b1;
    q(2);
    sda_pull <= 1'b0;
    q(2);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = (s === 1'b0);
  endtask
  // Last byte of a read is not acknowledged, the caller then stops
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(last, s);
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct packed {logic [9:0] a; logic [7:0] d; logic s;} ee_row_t;
  logic ref_clk, rst_n, scl, sda_pull, sda, sda_out, sda_oe, strap, wp, mem_we, busy;
  logic [9:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] mem [1024];
  logic [7:0] ref_m [1024];
  logic oe_busy = 1'b0;
  logic ack;
  int n, bad_count = 0, n_tests = 0, cycles = 0;
  ee_row_t rows [4] = '{'{10'h0ff, 8'h3c, 1'b0}, '{10'h100, 8'hc3, 1'b1},
                        '{10'h2a5, 8'h81, 1'b0}, '{10'h3ff, 8'h00, 1'b1}};
  // Open-drain wire with pull-up
  assign sda = !sda_pull & (sda_oe ? sda_out : 1'b1);
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  ee_mst ee_mst_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  ee_slave #(.WR_CYCLES(100)) ee_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_enable_strap(strap),
    .write_protect_in(wp), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_rdata(mem_rdata), .busy(busy));
  always @(posedge ref_clk) begin
    if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem[mem_addr];
    if (busy === 1'b1 && sda_oe !== 1'b0) oe_busy <= 1'b1;
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic sel(input logic [9:0] a, input logic rw, output logic k);
    ee_mst_inst.start();
    ee_mst_inst.wr({ee_pkg::DEV_TYPE_ID, strap, a[9:8], rw}, k);
  endtask
  // Select that must be ignored; the released line reads all ones
  task automatic nsel(input logic [7:0] b);
    logic k;
    logic [7:0] v;
    ee_mst_inst.start();
    ee_mst_inst.wr(b, k);
    check(k, 1'b0);
    ee_mst_inst.rd(1'b1, v);
    check(v, 8'hff);
    ee_mst_inst.stop();
  endtask
  task automatic wr_bytes(input logic [9:0] a, input int cnt, input logic [7:0] d0);
    logic k;
    sel(a, 1'b0, k);
    check(k, 1'b1);
    ee_mst_inst.wr(a[7:0], k);
    check(k, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      ee_mst_inst.wr(d0 + i[7:0], k);
      check(k, !wp);
      if (!wp) ref_m[{a[9:4], a[3:0] + i[3:0]}] = d0 + i[7:0];
    end
    ee_mst_inst.stop();
  endtask
  // Polls with a write select carrying the upper bits of a; a write select alone never moves the address counter
  task automatic poll(input logic [9:0] a, output int cnt);
    logic k;
    cnt = 0;
    k = 1'b0;
    while (!k && cnt < 40) begin
      sel(a, 1'b0, k);
      ee_mst_inst.stop();
      cnt++;
    end
    check(k, 1'b1);
  endtask
  task automatic rd_seq(input logic dummy, input logic [9:0] a, input int cnt);
    logic k;
    logic [7:0] v;
    logic [9:0] p;
    p = a;
    if (dummy) begin
      sel(a, 1'b0, k);
      ee_mst_inst.wr(a[7:0], k);
    end
    sel(a, 1'b1, k);
    check(k, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      ee_mst_inst.rd(i == cnt - 1, v);
      check(v, ref_m[p]);
      p = p + 10'h001;
    end
    ee_mst_inst.stop();
  endtask
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    wp = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
      ref_m[i] = i[7:0] ^ 8'h5a;
    end
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    check({sda_oe, busy, mem_we}, 3'h0);
    check(mem_addr, 10'h000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd_seq(1'b0, 10'h000, 2);
    foreach (rows[r]) begin
      strap <= rows[r].s;
      repeat (4) @(posedge ref_clk);
      nsel({ee_pkg::DEV_TYPE_ID, !rows[r].s, 3'h1});
      nsel({~ee_pkg::DEV_TYPE_ID, rows[r].s, 3'h1});
      wr_bytes(rows[r].a, 1, rows[r].d);
      poll(rows[r].a, n);
      check(n > 1, 1'b1);
      rd_seq(1'b0, rows[r].a + 10'h001, 1);
      rd_seq(1'b1, rows[r].a, 1);
    end
    // Page write past the page end wraps inside the page
    wr_bytes(10'h13e, 18, 8'h40);
    poll(10'h140, n);
    rd_seq(1'b0, 10'h140, 1);
    rd_seq(1'b1, 10'h130, 16);
    wp <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr_bytes(10'h050, 2, 8'h99);
    repeat (20) @(posedge ref_clk);
    check(busy, 1'b0);
    poll(10'h050, n);
    check(n, 10'h001);
    rd_seq(1'b1, 10'h050, 2);
    wp <= 1'b0;
    sel(10'h060, 1'b0, ack);
    ee_mst_inst.wr(8'h60, ack);
    ee_mst_inst.stop();
    repeat (20) @(posedge ref_clk);
    check(busy, 1'b0);
    poll(10'h060, n);
    check(n, 10'h001);
    ee_mst_inst.start();
    repeat (3) ee_mst_inst.bit_x(1'b1, ack);
    rd_seq(1'b0, 10'h060, 1);
    rd_seq(1'b1, 10'h3fe, 4);
    check(oe_busy, 1'b0);
    check(sda_out, 1'b0);
    for (int i = 0; i < 1024; i++) begin
      if (mem[i] !== ref_m[i]) check(mem[i], ref_m[i]);
    end
    give_verdict();
  end
endmodule

// >>> verilog/ee_pkg.sv
package ee_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SELF_TIMED_WRITE_TIME_NS = 5000000;
  // Longest time, so the cycle count rounds down
  localparam int WR_CYCLES_DFLT = SELF_TIMED_WRITE_TIME_NS / CLK_PERIOD_NS;
  // Device type code; the value is arbitrary
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [3:0] SLOT_POST_ACK = 4'h9;
  localparam logic [3:0] SLOT_STOP = 4'h1;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] PAGE_LAST = 4'hf;
  localparam logic [9:0] ADDR_RST = 10'h000;
  localparam logic [4:0] NBYTES_RST = 5'h00;
  localparam int SEL_ID_MSB = 7;
  localparam int SEL_ID_LSB = 4;
  localparam int SEL_CE_BIT = 3;
  localparam int SEL_AHI_MSB = 2;
  localparam int SEL_AHI_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam int PAGE_BYTES = 16;

  typedef enum logic [2:0] {
    SM_IDLE = 3'h0,
    SM_SEL = 3'h1,
    SM_WADDR = 3'h2,
    SM_WDATA = 3'h3,
    SM_RDATA = 3'h4,
    SM_COMMIT = 3'h5,
    SM_WAIT = 3'h6
  } ee_state_t;
endpackage

// >>> verilog/ee_slave.sv
`timescale 1ns/10ps
module ee_slave #(
  parameter int WR_CYCLES = ee_pkg::WR_CYCLES_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_enable_strap,
  input wire logic write_protect_in,
  output logic [9:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata,
  output logic busy
);
  localparam int TW_W = $clog2(WR_CYCLES + 1);

  generate
    if (WR_CYCLES < 1) begin : g_bad_cycles
      $error("WR_CYCLES must be at least one");
    end
  endgenerate

  function automatic logic sel_match(input logic [7:0] b, input logic ce);
    sel_match = (b[ee_pkg::SEL_ID_MSB:ee_pkg::SEL_ID_LSB] == ee_pkg::DEV_TYPE_ID) &&
                (b[ee_pkg::SEL_CE_BIT] == ce);
  endfunction

  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic ce_m_r, ce_s_r, wp_m_r, wp_s_r;
  ee_pkg::ee_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic rw_r;
  logic [1:0] addr_hi_r;
  logic [9:0] addr_cnt_r;
  logic [3:0] cidx_r;
  logic [TW_W-1:0] tw_cnt_r;
  logic [7:0] buf_r [ee_pkg::PAGE_BYTES];
  logic [ee_pkg::PAGE_BYTES-1:0] mask_r;
  logic [3:0] pg_off_r, last_off_r;
  logic [4:0] nbytes_r;
  logic scl_rise, scl_fall, start_det, stop_det, in_wr_cycle, take_byte, load_addr, stop_write;

  // Second stage feeds the edge detectors, the bit sampling and the strap/protect logic; first stage is never read elsewhere
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      ce_m_r <= 1'b0;
      ce_s_r <= 1'b0;
      wp_m_r <= 1'b0;
      wp_s_r <= 1'b0;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      ce_m_r <= chip_enable_strap;
      ce_s_r <= ce_m_r;
      wp_m_r <= write_protect_in;
      wp_s_r <= wp_m_r;
    end
  end

  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;
  assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_det = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  assign in_wr_cycle = (state_r == ee_pkg::SM_COMMIT) || (state_r == ee_pkg::SM_WAIT);
  // Protect input only gates data bytes of a write
  assign take_byte = (state_r == ee_pkg::SM_WDATA) && scl_fall &&
                     (bit_cnt_r == ee_pkg::SLOT_ACK) && !wp_s_r;
  assign load_addr = (state_r == ee_pkg::SM_WADDR) && scl_fall && (bit_cnt_r == ee_pkg::SLOT_ACK);
  // The stop's own SCL rise has already counted slot one of the next byte
  assign stop_write = stop_det && (state_r == ee_pkg::SM_WDATA) &&
                      (bit_cnt_r == ee_pkg::SLOT_STOP) &&
                      (nbytes_r != ee_pkg::NBYTES_RST) && !wp_s_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ee_pkg::SM_IDLE;
      bit_cnt_r <= ee_pkg::SLOT_FIRST;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      rw_r <= 1'b0;
      addr_hi_r <= 2'h0;
      addr_cnt_r <= ee_pkg::ADDR_RST;
      cidx_r <= 4'h0;
      tw_cnt_r <= '0;
      sda_oe <= 1'b0;
    end else if (state_r == ee_pkg::SM_COMMIT) begin
      sda_oe <= 1'b0;
      cidx_r <= cidx_r + 4'h1;
      if (cidx_r == ee_pkg::PAGE_LAST) begin
        state_r <= ee_pkg::SM_WAIT;
      end
    end else if (state_r == ee_pkg::SM_WAIT) begin
      sda_oe <= 1'b0;
      tw_cnt_r <= tw_cnt_r + 1'b1;
      if (tw_cnt_r == TW_W'(WR_CYCLES - 1)) begin
        state_r <= ee_pkg::SM_IDLE;
        tw_cnt_r <= '0;
        addr_cnt_r <= {addr_cnt_r[9:4], last_off_r} + 10'h001;
      end
    end else if (start_det) begin
      state_r <= ee_pkg::SM_SEL;
      bit_cnt_r <= ee_pkg::SLOT_FIRST;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_r <= stop_write ? ee_pkg::SM_COMMIT : ee_pkg::SM_IDLE;
      cidx_r <= 4'h0;
      sda_oe <= 1'b0;
    end else if (state_r != ee_pkg::SM_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_r < ee_pkg::SLOT_ACK) begin
          rx_sh_r <= {rx_sh_r[6:0], sda_s_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (bit_cnt_r == ee_pkg::SLOT_ACK) begin
          bit_cnt_r <= ee_pkg::SLOT_POST_ACK;
          if (state_r == ee_pkg::SM_RDATA && sda_s_r) begin
            state_r <= ee_pkg::SM_IDLE;
          end
        end
      end else if (scl_fall) begin
        if (bit_cnt_r == ee_pkg::SLOT_ACK) begin
          case (state_r)
            ee_pkg::SM_SEL: begin
              if (sel_match(rx_sh_r, ce_s_r)) begin
                sda_oe <= 1'b1;
                rw_r <= rx_sh_r[ee_pkg::SEL_RW_BIT];
                if (!rx_sh_r[ee_pkg::SEL_RW_BIT]) begin
                  addr_hi_r <= rx_sh_r[ee_pkg::SEL_AHI_MSB:ee_pkg::SEL_AHI_LSB];
                end
              end else begin
                state_r <= ee_pkg::SM_IDLE;
              end
            end
            ee_pkg::SM_WADDR: begin
              sda_oe <= 1'b1;
              addr_cnt_r <= {addr_hi_r, rx_sh_r};
            end
            ee_pkg::SM_WDATA: begin
              sda_oe <= !wp_s_r;
            end
            default: begin
              sda_oe <= 1'b0;
            end
          endcase
        end else if (bit_cnt_r == ee_pkg::SLOT_POST_ACK) begin
          bit_cnt_r <= ee_pkg::SLOT_FIRST;
          sda_oe <= 1'b0;
          case (state_r)
            ee_pkg::SM_SEL: begin
              state_r <= rw_r ? ee_pkg::SM_RDATA : ee_pkg::SM_WADDR;
            end
            ee_pkg::SM_WADDR: begin
              state_r <= ee_pkg::SM_WDATA;
            end
            default: begin
              state_r <= state_r;
            end
          endcase
          // Counter moves on at load, so the next byte is ready before the ack
          if ((state_r == ee_pkg::SM_SEL && rw_r) || state_r == ee_pkg::SM_RDATA) begin
            tx_sh_r <= mem_rdata;
            sda_oe <= !mem_rdata[7];
            addr_cnt_r <= addr_cnt_r + 10'h001;
          end
        end else if (state_r == ee_pkg::SM_RDATA) begin
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          sda_oe <= !tx_sh_r[6];
        end
      end
    end
  end

  // Page buffer lets the master stream bytes while the array stays untouched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= '0;
      pg_off_r <= 4'h0;
      last_off_r <= 4'h0;
      nbytes_r <= ee_pkg::NBYTES_RST;
      for (int i = 0; i < ee_pkg::PAGE_BYTES; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else if (load_addr) begin
      mask_r <= '0;
      pg_off_r <= rx_sh_r[3:0];
      nbytes_r <= ee_pkg::NBYTES_RST;
    end else if (take_byte) begin
      buf_r[pg_off_r] <= rx_sh_r;
      mask_r[pg_off_r] <= 1'b1;
      last_off_r <= pg_off_r;
      pg_off_r <= pg_off_r + 4'h1;
      if (nbytes_r != 5'h10) begin
        nbytes_r <= nbytes_r + 5'h01;
      end
    end
  end

  // Drains the buffered page to the array, one byte per clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= ee_pkg::ADDR_RST;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      busy <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      busy <= in_wr_cycle;
      mem_we <= (state_r == ee_pkg::SM_COMMIT) && mask_r[cidx_r];
      mem_wdata <= buf_r[cidx_r];
      mem_addr <= (state_r == ee_pkg::SM_COMMIT) ? {addr_cnt_r[9:4], cidx_r} : addr_cnt_r;
    end
  end

  property p_stop_write;
    @(posedge ref_clk) disable iff (!rst_n)
    stop_write && !in_wr_cycle |=> state_r == ee_pkg::SM_COMMIT ##16 state_r == ee_pkg::SM_WAIT;
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("Write cycle not started");

  property p_stop_nowrite;
    @(posedge ref_clk) disable iff (!rst_n)
    stop_det && !stop_write && !in_wr_cycle |=> state_r == ee_pkg::SM_IDLE && !sda_oe;
  endproperty
  a_stop_nowrite: assert property (p_stop_nowrite) else $error("Stray stop started write");

  property p_busy_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    in_wr_cycle && start_det |=> !sda_oe && $stable(bit_cnt_r);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("Bus served during write");

  property p_wp_nack;
    @(posedge ref_clk) disable iff (!rst_n)
    state_r == ee_pkg::SM_WDATA && scl_fall && bit_cnt_r == ee_pkg::SLOT_ACK && wp_s_r
      |=> !sda_oe && $stable(mask_r);
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("Protected byte acknowledged");

  property p_we_in_commit;
    @(posedge ref_clk) disable iff (!rst_n)
    mem_we |-> $past(state_r) == ee_pkg::SM_COMMIT;
  endproperty
  a_we_in_commit: assert property (p_we_in_commit) else $error("Array written outside cycle");

  property p_sel;
    @(posedge ref_clk) disable iff (!rst_n)
    state_r == ee_pkg::SM_SEL && scl_fall && bit_cnt_r == ee_pkg::SLOT_ACK
      |=> sda_oe == sel_match($past(rx_sh_r), ce_s_r) &&
          (sda_oe || state_r == ee_pkg::SM_IDLE);
  endproperty
  a_sel: assert property (p_sel) else $error("Select answer wrong");

  property p_addr_load;
    @(posedge ref_clk) disable iff (!rst_n)
    load_addr |=> sda_oe && addr_cnt_r == {addr_hi_r, $past(rx_sh_r)};
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("Word address not taken");

  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
    start_det && !in_wr_cycle |=> state_r == ee_pkg::SM_SEL && bit_cnt_r == ee_pkg::SLOT_FIRST;
  endproperty
  a_start: assert property (p_start) else $error("Start did not restart");

  property p_rd_nack;
    @(posedge ref_clk) disable iff (!rst_n)
    state_r == ee_pkg::SM_RDATA && scl_rise && bit_cnt_r == ee_pkg::SLOT_ACK && sda_s_r
      |=> state_r == ee_pkg::SM_IDLE && !sda_oe;
  endproperty
  a_rd_nack: assert property (p_rd_nack) else $error("Read went on after nack");

  property p_rd_inc;
    @(posedge ref_clk) disable iff (!rst_n)
    state_r == ee_pkg::SM_SEL && rw_r && scl_fall && bit_cnt_r == ee_pkg::SLOT_POST_ACK
      |=> addr_cnt_r == $past(addr_cnt_r) + 10'h001 && sda_oe == !$past(mem_rdata[7]);
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("Read counter not advanced");

  property p_wait_end;
    @(posedge ref_clk) disable iff (!rst_n)
    state_r == ee_pkg::SM_WAIT && tw_cnt_r == TW_W'(WR_CYCLES - 1)
      |=> state_r == ee_pkg::SM_IDLE && addr_cnt_r == {$past(addr_cnt_r[9:4]), last_off_r} + 10'h001;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("Counter wrong after write");

  property p_od;
    @(posedge ref_clk) disable iff (!rst_n)
    !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("SDA driven high");

  c_write: cover property (@(posedge ref_clk) disable iff (!rst_n) stop_write);
  c_wp: cover property (@(posedge ref_clk) disable iff (!rst_n) take_byte == 1'b0 && wp_s_r &&
    state_r == ee_pkg::SM_WDATA && scl_fall && bit_cnt_r == ee_pkg::SLOT_ACK);
  c_seq_rd: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ee_pkg::SM_RDATA && scl_rise && bit_cnt_r == ee_pkg::SLOT_ACK && !sda_s_r);
  c_poll: cover property (@(posedge ref_clk) disable iff (!rst_n) in_wr_cycle && start_det);
endmodule
